// ==== common/pdog_pkg.sv ====
package pdog_pkg;

  // ***************************************************************
  // Widths
  // ***************************************************************
  localparam int DEV_W = 32;               // Deviation counter width
  localparam int LIM_W = 30;               // Limit register width
  localparam int PCT_W = 7;                // Percentage width
  localparam int SPD_W = 14;               // Speed cap width
  localparam int EV_N  = 5;                // Number of events

  // ***************************************************************
  // Ranges and reset values
  // ***************************************************************
  localparam logic [LIM_W-1:0] LIM_MIN = 30'h0000_0001;
  localparam logic [LIM_W-1:0] LIM_MAX = 30'h3fff_ffff;
  localparam logic [LIM_W-1:0] LIM_RST = 30'h0050_0000;
  localparam logic [PCT_W-1:0] PCT_MIN = 7'h0a;
  localparam logic [PCT_W-1:0] PCT_MAX = 7'h64;
  localparam logic [PCT_W-1:0] PCT_RST = 7'h64;
  localparam logic [PCT_W-1:0] PCT_ONE = 7'h64;   // Hundred percent scale
  localparam logic [SPD_W-1:0] SPD_MIN = 14'h0000;
  localparam logic [SPD_W-1:0] SPD_MAX = 14'h2710;
  localparam logic [SPD_W-1:0] SPD_RST = 14'h2710;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_ALM_LIM  = 12'h004;
  localparam logic [11:0] OFS_WARN_PCT = 12'h008;
  localparam logic [11:0] OFS_SON_LIM  = 12'h00c;
  localparam logic [11:0] OFS_SON_PCT  = 12'h010;
  localparam logic [11:0] OFS_SON_CAP  = 12'h014;
  localparam logic [11:0] OFS_ALT_CAP  = 12'h018;
  localparam logic [11:0] OFS_STATUS   = 12'h01c;
  localparam logic [11:0] OFS_IRQ_EN   = 12'h020;
  localparam logic [11:0] OFS_IRQ_CLR  = 12'h024;
  localparam logic [11:0] OFS_DEV      = 12'h028;
  localparam logic [11:0] OFS_STATE    = 12'h02c;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int CTRL_ALT_BIT = 0;         // Select alternate speed cap
  localparam int EV_DEV_ALM   = 0;         // Deviation overflow alarm
  localparam int EV_DEV_WARN  = 1;         // Deviation overflow warning
  localparam int EV_SON_ALM   = 2;         // Servo-on overflow alarm
  localparam int EV_CAP_ALM   = 3;         // Speed-capped overflow alarm
  localparam int EV_SON_WARN  = 4;         // Servo-on overflow warning
  localparam logic [EV_N-1:0] ALM_MASK = 5'h0d;

  // Servo phase, Gray coded along off, capped, on
  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_CAPPED = 2'b01,
    ST_ON     = 2'b11
  } pdog_state_t;

  // Position increments from the loop
  typedef struct packed {
    logic                    ref_valid;
    logic signed [DEV_W-1:0] ref_delta;
    logic                    fb_valid;
    logic signed [DEV_W-1:0] fb_delta;
  } pdog_motion_t;

  // Commands toward the drive stage
  typedef struct packed {
    logic             motor_stop;
    logic             cap_active;
    logic [SPD_W-1:0] cap_speed;
  } pdog_drive_t;

endpackage : pdog_pkg

// ==== hw/pdog_thresh.sv ====
`timescale 1ns/1ps
module pdog_thresh
  import pdog_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [DEV_W-1:0] mag,        // Deviation magnitude
  input  wire logic [LIM_W-1:0] limit,      // Alarm limit
  input  wire logic [PCT_W-1:0] pct,        // Warning percentage
  output logic                  over_lim_r, // Magnitude above limit
  output logic                  over_warn_r // Above limit*pct/100
);

  // ***************************************************************
  // Compare
  // ***************************************************************
  localparam int PW = DEV_W + PCT_W + 1;    // Product width, no overflow

  logic [PW-1:0] lhs;                       // Magnitude times hundred
  logic [PW-1:0] rhs;                       // Limit times percentage
  logic          over_lim_nxt;
  logic          over_warn_nxt;

  // Cross-multiplied so no divider is needed and no rounding creeps in
  always_comb begin
    lhs           = PW'(mag) * PW'(PCT_ONE);
    rhs           = PW'(limit) * PW'(pct);
    over_lim_nxt  = mag > DEV_W'(limit);
    over_warn_nxt = lhs > rhs;
  end

  // Flags registered to cut the multiplier path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_lim_r  <= 1'b0;
      over_warn_r <= 1'b0;
    end else begin
      over_lim_r  <= over_lim_nxt;
      over_warn_r <= over_warn_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_warn_level: assert property (lhs > rhs |=> over_warn_r)
    else $error("warning flag missed above scaled limit");

endmodule : pdog_thresh

// ==== hw/pdog_irq.sv ====
`timescale 1ns/1ps
module pdog_irq
  import pdog_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic [EV_N-1:0] evt,       // Event pulses
  input  wire logic            en_we,     // Enable register write
  input  wire logic            clr_we,    // Clear register write
  input  wire logic [EV_N-1:0] wdata,     // Write data
  output logic      [EV_N-1:0] status_r,  // Sticky status
  output logic      [EV_N-1:0] en_r,      // Interrupt enables
  output logic                 irq        // Level interrupt
);

  // ***************************************************************
  // Sticky status
  // ***************************************************************
  logic [EV_N-1:0] status_nxt;
  logic [EV_N-1:0] en_nxt;

  // Set wins over a clear in the same cycle so no event is lost
  always_comb begin
    status_nxt = (status_r & ~(clr_we ? wdata : '0)) | evt;
    en_nxt     = en_we ? wdata : en_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
      en_r     <= '0;
    end else begin
      status_r <= status_nxt;
      en_r     <= en_nxt;
    end
  end

  assign irq = |(status_r & en_r);

endmodule : pdog_irq

// ==== hw/pdog_guard.sv ====
`timescale 1ns/1ps
module pdog_guard
  import pdog_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         pos_mode,
  input  wire logic         servo_on_req,
  input  wire pdog_motion_t motion,
  output pdog_drive_t       drive,
  output logic              irq
);

  // ***************************************************************
  // Elaboration check
  // ***************************************************************
  if (DEV_W < LIM_W + 2) begin : g_chk
    $error("deviation counter too narrow for the limits");
  end

  // ***************************************************************
  // Register file
  // ***************************************************************
  logic             alt_sel_r, alt_sel_nxt;             // Alternate cap select
  logic [LIM_W-1:0] alm_lim_r, alm_lim_nxt;             // Alarm limit
  logic [PCT_W-1:0] warn_pct_r, warn_pct_nxt;           // Warning percent
  logic [LIM_W-1:0] son_lim_r, son_lim_nxt;             // Servo-on limit
  logic [PCT_W-1:0] son_pct_r, son_pct_nxt;             // Servo-on percent
  logic [SPD_W-1:0] son_cap_r, son_cap_nxt;             // Speed cap
  logic [SPD_W-1:0] alt_cap_r, alt_cap_nxt;             // Alternate speed cap
  logic [31:0]      prdata_nxt;
  logic             pslverr_nxt;
  logic             wr, rd;                             // Access strobes
  logic [EV_N-1:0]  status;                             // Sticky events
  logic [EV_N-1:0]  irq_en;                             // Interrupt enables

  // Range test shared by every limit write
  function automatic logic in_rng(input logic [31:0] v, input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction : in_rng

  // Known offset test used for reads and writes
  function automatic logic mapped(input logic [11:0] a);
    case (a)
      OFS_CTRL, OFS_ALM_LIM, OFS_WARN_PCT, OFS_SON_LIM, OFS_SON_PCT,
      OFS_SON_CAP, OFS_ALT_CAP, OFS_STATUS, OFS_IRQ_EN, OFS_IRQ_CLR,
      OFS_DEV, OFS_STATE: mapped = 1'b1;
      default:            mapped = 1'b0;
    endcase
  endfunction : mapped

  // Zero wait states; read data is latched in the setup cycle
  assign pready = 1'b1;
  assign wr     = psel && penable && pwrite;
  assign rd     = psel && !penable && !pwrite;

  logic signed [DEV_W-1:0] dev_r, dev_nxt;              // Deviation counter
  pdog_state_t             st_r, st_nxt;                // Servo phase

  // Register writes; out-of-range values are dropped, keeping the old one
  always_comb begin
    alt_sel_nxt  = alt_sel_r;
    alm_lim_nxt  = alm_lim_r;
    warn_pct_nxt = warn_pct_r;
    son_lim_nxt  = son_lim_r;
    son_pct_nxt  = son_pct_r;
    son_cap_nxt  = son_cap_r;
    alt_cap_nxt  = alt_cap_r;
    if (wr) begin
      case (paddr)
        OFS_CTRL:     alt_sel_nxt = pwdata[CTRL_ALT_BIT];
        OFS_ALM_LIM:  if (in_rng(pwdata, 32'(LIM_MIN), 32'(LIM_MAX))) begin
          alm_lim_nxt = pwdata[LIM_W-1:0];
        end
        OFS_WARN_PCT: if (in_rng(pwdata, 32'(PCT_MIN), 32'(PCT_MAX))) begin
          warn_pct_nxt = pwdata[PCT_W-1:0];
        end
        OFS_SON_LIM:  if (in_rng(pwdata, 32'(LIM_MIN), 32'(LIM_MAX))) begin
          son_lim_nxt = pwdata[LIM_W-1:0];
        end
        OFS_SON_PCT:  if (in_rng(pwdata, 32'(PCT_MIN), 32'(PCT_MAX))) begin
          son_pct_nxt = pwdata[PCT_W-1:0];
        end
        OFS_SON_CAP:  if (in_rng(pwdata, 32'(SPD_MIN), 32'(SPD_MAX))) begin
          son_cap_nxt = pwdata[SPD_W-1:0];
        end
        OFS_ALT_CAP:  if (in_rng(pwdata, 32'(SPD_MIN), 32'(SPD_MAX))) begin
          alt_cap_nxt = pwdata[SPD_W-1:0];
        end
        default: ;
      endcase
    end
  end

  // Read mux, error flag for unmapped offsets
  always_comb begin
    prdata_nxt  = prdata;
    pslverr_nxt = 1'b0;
    if (rd) begin
      case (paddr)
        OFS_CTRL:     prdata_nxt = 32'(alt_sel_r);
        OFS_ALM_LIM:  prdata_nxt = 32'(alm_lim_r);
        OFS_WARN_PCT: prdata_nxt = 32'(warn_pct_r);
        OFS_SON_LIM:  prdata_nxt = 32'(son_lim_r);
        OFS_SON_PCT:  prdata_nxt = 32'(son_pct_r);
        OFS_SON_CAP:  prdata_nxt = 32'(son_cap_r);
        OFS_ALT_CAP:  prdata_nxt = 32'(alt_cap_r);
        OFS_STATUS:   prdata_nxt = 32'(status);
        OFS_IRQ_EN:   prdata_nxt = 32'(irq_en);
        OFS_DEV:      prdata_nxt = dev_r;
        OFS_STATE:    prdata_nxt = 32'(st_r);
        default:      prdata_nxt = '0;
      endcase
    end
    if (psel && !penable) begin
      pslverr_nxt = !mapped(paddr);
    end else if (psel) begin
      pslverr_nxt = pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_sel_r  <= 1'b0;
      alm_lim_r  <= LIM_RST;
      warn_pct_r <= PCT_RST;
      son_lim_r  <= LIM_RST;
      son_pct_r  <= PCT_RST;
      son_cap_r  <= SPD_RST;
      alt_cap_r  <= SPD_RST;
      prdata     <= '0;
      pslverr    <= 1'b0;
    end else begin
      alt_sel_r  <= alt_sel_nxt;
      alm_lim_r  <= alm_lim_nxt;
      warn_pct_r <= warn_pct_nxt;
      son_lim_r  <= son_lim_nxt;
      son_pct_r  <= son_pct_nxt;
      son_cap_r  <= son_cap_nxt;
      alt_cap_r  <= alt_cap_nxt;
      prdata     <= prdata_nxt;
      pslverr    <= pslverr_nxt;
    end
  end

  // ***************************************************************
  // Deviation counter and limit checks
  // ***************************************************************
  logic [DEV_W-1:0] mag;                                // Deviation magnitude
  logic             over_lim, over_warn;                // Running limits
  logic             son_over_lim, son_over_warn;        // Servo-on limits

  // Counter wraps silently; limits stay far below its range
  always_comb begin
    dev_nxt = dev_r;
    if (motion.ref_valid) begin
      dev_nxt = dev_nxt + motion.ref_delta;
    end
    if (motion.fb_valid) begin
      dev_nxt = dev_nxt - motion.fb_delta;
    end
    mag = dev_r[DEV_W-1] ? DEV_W'(-dev_r) : DEV_W'(dev_r);
  end

  pdog_thresh u_run (
    .pclk        (pclk),
    .presetn     (presetn),
    .mag         (mag),
    .limit       (alm_lim_r),
    .pct         (warn_pct_r),
    .over_lim_r  (over_lim),
    .over_warn_r (over_warn)
  );

  pdog_thresh u_son (
    .pclk        (pclk),
    .presetn     (presetn),
    .mag         (mag),
    .limit       (son_lim_r),
    .pct         (son_pct_r),
    .over_lim_r  (son_over_lim),
    .over_warn_r (son_over_warn)
  );

  // ***************************************************************
  // Servo phase and events
  // ***************************************************************
  logic            son_q_r;                             // Last servo-on request
  logic            son_edge;                            // Servo-on rising edge
  logic            alm_any;                             // Any alarm pending
  logic [EV_N-1:0] evt;                                 // Event pulses
  logic            ref_seen_r, ref_seen_nxt;            // Reference in capped phase
  pdog_drive_t     drive_nxt;

  // Events only fire in position control mode; the capped alarm keys on a
  // remembered reference, since the flags trail a single reference pulse
  always_comb begin
    son_edge = servo_on_req && !son_q_r;
    alm_any  = |(status & ALM_MASK);
    evt      = '0;
    if (pos_mode) begin
      evt[EV_DEV_ALM]  = (st_r == ST_ON) && over_lim;
      evt[EV_DEV_WARN] = (st_r != ST_OFF) && over_warn;
      evt[EV_SON_ALM]  = (st_r == ST_OFF) && son_edge && son_over_lim;
      evt[EV_SON_WARN] = (st_r == ST_OFF) && son_edge && son_over_warn;
      evt[EV_CAP_ALM]  = (st_r == ST_CAPPED) && ref_seen_r && over_lim;
    end
  end

  // Phase: an alarm or servo-off drops to off; in position mode leftover deviation caps speed
  always_comb begin
    // Cleared on leaving the capped phase so no stale reference is replayed
    ref_seen_nxt = (st_r == ST_CAPPED) && (ref_seen_r || motion.ref_valid);
    st_nxt = st_r;
    case (st_r)
      ST_OFF: begin
        if (!pos_mode && servo_on_req) begin
          st_nxt = ST_ON;
        end else if (son_edge && !son_over_lim && !alm_any) begin
          st_nxt = (dev_r != '0) ? ST_CAPPED : ST_ON;
        end
      end
      ST_CAPPED: begin
        if (dev_r == '0) begin
          st_nxt = ST_ON;
        end
      end
      ST_ON: ;
      default: st_nxt = ST_OFF;
    endcase
    if (!servo_on_req || (pos_mode && |(evt & ALM_MASK))) begin
      st_nxt = ST_OFF;
    end
  end

  // Drive commands registered from phase and alarm state
  always_comb begin
    drive_nxt.motor_stop = alm_any || |(evt & ALM_MASK);
    drive_nxt.cap_active = (st_r == ST_CAPPED);
    drive_nxt.cap_speed  = alt_sel_r ? alt_cap_r : son_cap_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_r   <= '0;
      st_r    <= ST_OFF;
      son_q_r <= 1'b0;
      ref_seen_r <= 1'b0;
      drive   <= '{motor_stop: 1'b0, cap_active: 1'b0, cap_speed: SPD_RST};
    end else begin
      dev_r   <= dev_nxt;
      st_r    <= st_nxt;
      son_q_r <= servo_on_req;
      ref_seen_r <= ref_seen_nxt;
      drive   <= drive_nxt;
    end
  end

  pdog_irq u_irq (
    .pclk     (pclk),
    .presetn  (presetn),
    .evt      (evt),
    .en_we    (wr && (paddr == OFS_IRQ_EN)),
    .clr_we   (wr && (paddr == OFS_IRQ_CLR)),
    .wdata    (pwdata[EV_N-1:0]),
    .status_r (status),
    .en_r     (irq_en),
    .irq      (irq)
  );

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mode_gate: assert property (!pos_mode |-> evt == '0)
    else $error("event raised outside position mode");
  a_dev_sum: assert property (motion.ref_valid && !motion.fb_valid
      |=> dev_r == $past(dev_r) + $past(motion.ref_delta))
    else $error("deviation did not follow reference");
  a_dev_alarm: assert property (pos_mode && st_r == ST_ON && over_lim
      |=> status[EV_DEV_ALM] && st_r == ST_OFF)
    else $error("deviation alarm not raised");
  a_stop_hold: assert property (|(status & ALM_MASK) |-> drive.motor_stop)
    else $error("motor not stopped under alarm");
  a_son_alarm: assert property (pos_mode && st_r == ST_OFF && son_edge && son_over_lim
      |=> status[EV_SON_ALM] && st_r == ST_OFF)
    else $error("servo-on alarm missing");
  a_cap_phase: assert property (st_r == ST_CAPPED |=> drive.cap_active)
    else $error("speed cap not applied");
  a_cap_alarm: assert property (pos_mode && st_r == ST_CAPPED && ref_seen_r
      && over_lim |=> status[EV_CAP_ALM])
    else $error("capped phase alarm missing");
  a_ref_seen: assert property (st_r == ST_CAPPED && motion.ref_valid |=> ref_seen_r)
    else $error("capped phase reference not remembered");
  a_son_warn: assert property (pos_mode && st_r == ST_OFF && son_edge && son_over_warn
      |=> status[EV_SON_WARN])
    else $error("servo-on warning missing");
  a_neg_dev: assert property ($signed(dev_r) < -$signed({2'b00, alm_lim_r})
      |=> over_lim)
    else $error("negative overflow not detected");

  c_capped_to_on: cover property (st_r == ST_CAPPED ##1 st_r == ST_ON);
  c_son_alarm:    cover property (evt[EV_SON_ALM]);
  c_dev_alarm:    cover property (evt[EV_DEV_ALM] ##1 drive.motor_stop);
  c_irq:          cover property (irq);
  c_cap_alarm:    cover property (evt[EV_CAP_ALM]);

endmodule : pdog_guard

// ==== tb/pdog_host.sv ====
`timescale 1ns/1ps
// ***************************************************************
// Host motion controller model
// ***************************************************************
module pdog_host
  import pdog_pkg::*;
(
  input  wire logic   pclk,         // Drive clock
  output pdog_motion_t motion,      // Increments toward the loop
  output logic        servo_on_req  // Servo-on request level
);
  // Quiet at time zero, servo off
  initial begin
    motion       = '0;
    servo_on_req = 1'b0;
  end

  // One cycle of increments; idle deltas are inverted so a stale
  // value can never pass for a fresh one
  task automatic send(input logic signed [DEV_W-1:0] r,
                      input logic signed [DEV_W-1:0] f);
    @(posedge pclk);
    motion <= '{1'b1, r, 1'b1, f};
    @(posedge pclk);
    motion <= '{1'b0, ~r, 1'b0, ~f};
  endtask : send

  // Request level changes only just after an edge
  task automatic servo(input logic on);
    @(posedge pclk);
    servo_on_req <= on;
  endtask : servo
endmodule : pdog_host

// ==== tb/position_deviation_overflow_guard_bench.sv ====
`timescale 1ns/1ps
module position_deviation_overflow_guard_bench
  import pdog_pkg::*;
;
  // ***************************************************************
  // Signals
  // ***************************************************************
  logic               pclk, presetn;          // Clock, reset
  logic               psel, penable, pwrite;  // APB controls
  logic        [11:0] paddr;                  // APB address
  logic        [31:0] pwdata, prdata, q;      // Data, last read
  logic               pready, pslverr, err;   // Answer, last error
  logic               pos_mode, servo_on_req, irq;
  pdog_motion_t       motion;                 // From host model
  pdog_drive_t        drive;                  // To drive stage
  logic         [4:0] en_x;                   // Expected enables
  int                 n_mismatch, samples_checked, seed;
  longint             lim, pct, cap, alt, m;  // Chosen settings
  logic signed [31:0] d;                      // Signed deviation

  pdog_guard dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pos_mode(pos_mode), .servo_on_req(servo_on_req),
    .motion(motion), .drive(drive), .irq(irq));
  pdog_host host (.pclk(pclk), .motion(motion), .servo_on_req(servo_on_req));

  // 25 MHz clock
  always #20 pclk = ~pclk;

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic conclude();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, v};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(32'h0000_0000, 32'h0000_0001, "no pready");
      conclude();
    end
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    // Idle bus carries junk; the slave must look only under psel
    pwrite <= 1'($urandom);
    paddr  <= 12'($urandom);
    pwdata <= $urandom;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, e, "read data");
  endtask : rd

  // Status under mask k, plus the stop and interrupt levels
  task automatic st(input logic [4:0] e, input logic [4:0] k);
    repeat (4) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(q & 32'(k), 32'(e & k), "status");
    chk(32'(drive.motor_stop), 32'(|(e & ALM_MASK)), "motor stop");
    chk(32'(irq), 32'(|(e & en_x)), "irq level");
  endtask : st

  // Strictly-above test of v against l*p/100
  function automatic logic over(input longint v, input longint l, input longint p);
    return v * 100 > l * p;
  endfunction : over

  // ***************************************************************
  // Watchdog: a hang counts as a mismatch
  // ***************************************************************
  initial begin
    repeat (100000) @(posedge pclk);
    chk(32'h0000_0000, 32'h0000_0001, "timeout");
    conclude();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pos_mode = 1'b1;
    en_x = 5'h1f;
    seed = $urandom(32'h0428_f798);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, unmapped place, refused values
    rd(OFS_ALM_LIM, 32'(LIM_RST));
    rd(OFS_WARN_PCT, 32'(PCT_RST));
    rd(OFS_SON_LIM, 32'(LIM_RST));
    rd(OFS_SON_PCT, 32'(PCT_RST));
    rd(OFS_SON_CAP, 32'(SPD_RST));
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001, "unmapped error");
    wr(OFS_WARN_PCT, 32'h0000_0009);
    rd(OFS_WARN_PCT, 32'(PCT_RST));
    wr(OFS_ALM_LIM, 32'h0000_0000);
    rd(OFS_ALM_LIM, 32'(LIM_RST));
    // Settings; fixed limit of 1000, below the random swing of up to 2000
    lim = 1000;
    pct = $urandom_range(100, 10);
    cap = $urandom_range(10000, 0);
    alt = $urandom_range(10000, 0);
    wr(OFS_ALM_LIM, 32'(lim));
    wr(OFS_WARN_PCT, 32'(pct));
    wr(OFS_SON_LIM, 32'd400);
    wr(OFS_SON_PCT, 32'd50);
    wr(OFS_SON_CAP, 32'(cap));
    wr(OFS_ALT_CAP, 32'(alt));
    wr(OFS_IRQ_EN, 32'(en_x));
    // Outside position control nothing trips
    pos_mode <= 1'b0;
    host.servo(1'b1);
    host.send(32'sd5000, 32'sd0);
    st(5'h00, 5'h1f);
    host.servo(1'b0);
    host.send(32'sd0, 32'sd5000);
    pos_mode <= 1'b1;
    // Leftover deviation at servo-on: capped phase
    host.send(32'sd300, 32'sd0);
    host.servo(1'b1);
    st({over(300, 400, 50), 2'b00, over(300, lim, pct), 1'b0}, 5'h1f);
    chk(32'(drive.cap_active), 32'h0000_0001, "cap active");
    chk(32'(drive.cap_speed), 32'(cap), "cap speed");
    wr(OFS_CTRL, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk(32'(drive.cap_speed), 32'(alt), "alt cap speed");
    rd(OFS_STATE, 32'(ST_CAPPED));
    // Reference during capped phase past the alarm limit
    host.send(32'sd800, 32'sd0);
    st(5'h1a, 5'h1e);
    host.servo(1'b0);
    wr(OFS_IRQ_CLR, 32'h0000_001f);
    st(5'h00, 5'h1f);
    // Servo-on with deviation over the servo-on limit
    host.servo(1'b1);
    st(5'h14, 5'h1f);
    rd(OFS_STATE, 32'(ST_OFF));
    host.servo(1'b0);
    host.send(32'sd0, 32'sd1100);
    wr(OFS_IRQ_CLR, 32'h0000_001f);
    rd(OFS_DEV, 32'h0000_0000);
    host.servo(1'b1);
    repeat (4) @(posedge pclk);
    rd(OFS_STATE, 32'(ST_ON));
    // Running phase: boundaries first, then random, both signs
    for (int i = 0; i < 10; i++) begin
      m = (i == 0) ? lim + 1 : (i == 1) ? lim : (i == 2) ? lim * pct / 100 :
          longint'($urandom_range(2000, 1));
      d = ($urandom_range(1, 0) != 0) ? 32'(-m) : 32'(m);
      en_x = 5'($urandom);
      pos_mode <= (i < 3) || ($urandom_range(1, 0) != 0);
      wr(OFS_IRQ_EN, 32'(en_x));
      host.send(d, 32'sd0);
      st({3'b000, pos_mode && over(m, lim, pct), pos_mode && over(m, lim, 100)},
         5'h1f);
      rd(OFS_DEV, d);
      host.servo(1'b0);
      host.send(32'sd0, d);
      wr(OFS_IRQ_CLR, 32'h0000_001f);
      host.servo(1'b1);
      repeat (4) @(posedge pclk);
    end
    conclude();
  end
endmodule : position_deviation_overflow_guard_bench
